/* core/tmr_consts.vh */
// Constants for the 16-bit timer with clear-on-match and fast PWM modes.
// Assumes inclusion by the timer core, its checker and the bench; holds definitions only.
`ifndef TMR_CONSTS_VH
`define TMR_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define TMR_OFF_CTRL 12'h000
`define TMR_OFF_COUNT 12'h004
`define TMR_OFF_CMPA 12'h008
`define TMR_OFF_CMPB 12'h00c
`define TMR_OFF_CAPTOP 12'h010
`define TMR_OFF_FLAGS 12'h014
`define TMR_OFF_STATUS 12'h018

// ----------------------------------------
// Control field positions and reset values
// ----------------------------------------
`define TMR_CTRL_MODE_LSB 0
`define TMR_CTRL_COMA_LSB 4
`define TMR_CTRL_PRE_LSB 8
`define TMR_CTRL_DIRA_BIT 11
`define TMR_CTRL_DIRB_BIT 12
`define TMR_CTRL_RST 13'h0000
`define TMR_CNT_RST 16'h0000
`define TMR_CMP_RST 16'h0000
`define TMR_CAP_RST 16'h0000

// ----------------------------------------
// Flag bit positions
// ----------------------------------------
`define TMR_FLG_OVF 0
`define TMR_FLG_MATCHA 1
`define TMR_FLG_CAP 3

// ----------------------------------------
// Waveform mode select codes
// ----------------------------------------
`define TMR_MODE_CTC_A 4'h4
`define TMR_MODE_CTC_CAP 4'hc
`define TMR_MODE_FP8 4'h5
`define TMR_MODE_FP9 4'h6
`define TMR_MODE_FP10 4'h7
`define TMR_MODE_FP_CAP 4'he
`define TMR_MODE_FP_A 4'hf

// ----------------------------------------
// Count limits
// ----------------------------------------
`define TMR_TOP_8 16'h00ff
`define TMR_TOP_9 16'h01ff
`define TMR_TOP_10 16'h03ff
`define TMR_MAX 16'hffff
`define TMR_BOTTOM 16'h0000

// ----------------------------------------
// Output action codes
// ----------------------------------------
`define TMR_COM_OFF 2'h0
`define TMR_COM_TOGGLE 2'h1
`define TMR_COM_LOW 2'h2
`define TMR_COM_HIGH 2'h3

// ----------------------------------------
// Prescale selects and terminal counts
// ----------------------------------------
`define TMR_PRE_DIV1 3'h1
`define TMR_PRE_DIV8 3'h2
`define TMR_PRE_DIV64 3'h3
`define TMR_PRE_DIV256 3'h4
`define TMR_PRE_DIV1024 3'h5
`define TMR_PRE_T1 10'h000
`define TMR_PRE_T8 10'h007
`define TMR_PRE_T64 10'h03f
`define TMR_PRE_T256 10'h0ff
`define TMR_PRE_T1024 10'h3ff

`endif

/* core/tmr_pwm.v */
// Timer core: 16-bit counter, two compare channels, limit register,
// prescaler, APB register slave and the two waveform pins.
// Assumes an APB master on pclk; port data inputs come from pclk logic.
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "tmr_consts.vh"

module tmr_pwm (
  input wire pclk,
  input wire presetn,
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire port_data_a,
  input wire port_data_b,
  output wire pin_out_a,
  output wire pin_oe_n_a,
  output wire pin_out_b,
  output wire pin_oe_n_b
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function [15:0] fix_mask;
    input [3:0] m;
    begin
      case (m)
        `TMR_MODE_FP8: fix_mask = `TMR_TOP_8;
        `TMR_MODE_FP9: fix_mask = `TMR_TOP_9;
        `TMR_MODE_FP10: fix_mask = `TMR_TOP_10;
        default: fix_mask = `TMR_MAX;
      endcase
    end
  endfunction

  function is_map;
    input [11:0] a;
    begin
      case (a)
        `TMR_OFF_CTRL,
        `TMR_OFF_COUNT,
        `TMR_OFF_CMPA,
        `TMR_OFF_CMPB,
        `TMR_OFF_CAPTOP,
        `TMR_OFF_FLAGS,
        `TMR_OFF_STATUS: is_map = 1'b1;
        default: is_map = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [12:0] ctrl_reg;
  reg [15:0] cnt_reg;
  reg [15:0] cnt_next;
  reg [15:0] cap_reg;
  reg ovf_reg;
  reg capf_reg;
  reg [9:0] pre_reg;
  reg [9:0] pre_term;
  reg pre_on;
  reg [15:0] top;

  wire [1:0] mflag_w;
  wire [1:0] wave_w;
  wire [31:0] act_w;
  wire [31:0] buf_w;

  wire [3:0] mode = ctrl_reg[`TMR_CTRL_MODE_LSB +: 4];
  wire [2:0] pre_sel = ctrl_reg[`TMR_CTRL_PRE_LSB +: 3];

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // Zero wait states; unmapped offsets answer with an error.
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~is_map(paddr);

  wire wr_en = psel & penable & pwrite & is_map(paddr);
  wire rd_setup = psel & ~penable & ~pwrite;
  wire wr_ctrl = wr_en & (paddr == `TMR_OFF_CTRL);
  wire wr_cap = wr_en & (paddr == `TMR_OFF_CAPTOP);
  wire wr_flags = wr_en & (paddr == `TMR_OFF_FLAGS);

  // Read data captured in setup so it is a flop in the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      case (paddr)
        `TMR_OFF_CTRL: prdata <= {19'h0, ctrl_reg};
        `TMR_OFF_COUNT: prdata <= {16'h0, cnt_reg};
        `TMR_OFF_CMPA: prdata <= {16'h0, buf_w[15:0]};
        `TMR_OFF_CMPB: prdata <= {16'h0, buf_w[31:16]};
        `TMR_OFF_CAPTOP: prdata <= {16'h0, cap_reg};
        `TMR_OFF_FLAGS: prdata <= {28'h0, capf_reg, mflag_w, ovf_reg};
        `TMR_OFF_STATUS: prdata <= {30'h0, wave_w};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `TMR_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg <= pwdata[12:0];
    end
  end

  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  // select divide factor
  always @* begin
    pre_on = 1'b1;
    case (pre_sel)
      `TMR_PRE_DIV1: pre_term = `TMR_PRE_T1;
      `TMR_PRE_DIV8: pre_term = `TMR_PRE_T8;
      `TMR_PRE_DIV64: pre_term = `TMR_PRE_T64;
      `TMR_PRE_DIV256: pre_term = `TMR_PRE_T256;
      `TMR_PRE_DIV1024: pre_term = `TMR_PRE_T1024;
      default: begin
        pre_term = `TMR_PRE_T1;
        pre_on = 1'b0;
      end
    endcase
  end

  wire tick = pre_on & (pre_reg >= pre_term);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg <= 10'h000;
    end else if (!pre_on || tick) begin
      pre_reg <= 10'h000;
    end else begin
      pre_reg <= pre_reg + 10'h001;
    end
  end

  // ----------------------------------------
  // Mode decode and limit
  // ----------------------------------------
  // fast PWM mode set
  wire is_fpwm = (mode == `TMR_MODE_FP8) | (mode == `TMR_MODE_FP9) |
                 (mode == `TMR_MODE_FP10) | (mode == `TMR_MODE_FP_CAP) |
                 (mode == `TMR_MODE_FP_A);
  wire is_ctc = (mode == `TMR_MODE_CTC_A) | (mode == `TMR_MODE_CTC_CAP);
  wire cap_top = (mode == `TMR_MODE_CTC_CAP) | (mode == `TMR_MODE_FP_CAP);
  wire a_top = (mode == `TMR_MODE_CTC_A) | (mode == `TMR_MODE_FP_A);

  always @* begin
    top = `TMR_MAX;
    if (cap_top) begin
      top = cap_reg;
    end else if (a_top) begin
      top = act_w[15:0];
    end else if (is_fpwm) begin
      top = fix_mask(mode);
    end
  end

  // Unsupported modes simply free-run to the maximum
  wire lim_ok = is_ctc | is_fpwm;
  wire at_top = lim_ok & (cnt_reg == top);
  wire at_max = (cnt_reg == `TMR_MAX);

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  // equality only, so a low limit waits for the wrap
  always @* begin
    if (at_top) begin
      cnt_next = `TMR_BOTTOM;
    end else begin
      cnt_next = cnt_reg + 16'h0001;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= `TMR_CNT_RST;
    end else if (tick) begin
      cnt_reg <= cnt_next;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_reg <= `TMR_CAP_RST;
    end else if (wr_cap) begin
      cap_reg <= pwdata[15:0];
    end
  end

  // ----------------------------------------
  // Overflow and limit flags
  // ----------------------------------------
  // set at the limit in fast PWM, else on the wrap from the maximum
  wire ovf_set = tick & (is_fpwm ? at_top : at_max);
  wire capf_set = tick & cap_top & at_top;

  // Set wins over a same-cycle clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_reg <= 1'b0;
      capf_reg <= 1'b0;
    end else begin
      ovf_reg <= ovf_set |
                 (ovf_reg & ~(wr_flags & pwdata[`TMR_FLG_OVF]));
      capf_reg <= capf_set |
                  (capf_reg & ~(wr_flags & pwdata[`TMR_FLG_CAP]));
    end
  end

  // ----------------------------------------
  // Compare channels
  // ----------------------------------------
  genvar k;
  generate
    for (k = 0; k < 2; k = k + 1) begin : g_ch
      localparam [11:0] CH_OFF = (k == 0) ? `TMR_OFF_CMPA : `TMR_OFF_CMPB;
      reg [15:0] buf_reg;
      reg [15:0] act_reg;
      reg mflag_reg;
      reg wave_reg;
      reg pin_reg;
      reg oe_n_reg;
      wire wr_cmp = wr_en & (paddr == CH_OFF);
      wire [1:0] com = ctrl_reg[`TMR_CTRL_COMA_LSB + 2 * k +: 2];
      wire dir = ctrl_reg[`TMR_CTRL_DIRA_BIT + k];
      wire port_d = (k == 0) ? port_data_a : port_data_b;
      wire match = (cnt_reg == act_reg);
      wire [15:0] wval = pwdata[15:0] & fix_mask(mode);

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          buf_reg <= `TMR_CMP_RST;
          act_reg <= `TMR_CMP_RST;
        end else begin
          if (wr_cmp) begin
            buf_reg <= wval;
          end
          if (wr_cmp && !is_fpwm) begin
            act_reg <= wval;
          end else if (tick && at_top && is_fpwm) begin
            act_reg <= buf_reg;
          end
        end
      end

      // flag after match tick, one clears
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mflag_reg <= 1'b0;
        end else begin
          mflag_reg <= (tick & match) |
                       (mflag_reg & ~(wr_flags & pwdata[`TMR_FLG_MATCHA + k]));
        end
      end

      // Waveform state, reset low
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          wave_reg <= 1'b0;
        end else if (tick) begin
          if (is_fpwm) begin
            case (com)
              // toggle only when A is the limit
              `TMR_COM_TOGGLE: begin
                if (k == 0 && mode == `TMR_MODE_FP_A && match) begin
                  wave_reg <= ~wave_reg;
                end
              end
              `TMR_COM_LOW: begin
                if (at_top) begin
                  wave_reg <= 1'b0;
                end else if (match) begin
                  wave_reg <= 1'b1;
                end
              end
              // clear on match, set at bottom
              `TMR_COM_HIGH: begin
                if (at_top) begin
                  wave_reg <= 1'b1;
                end else if (match) begin
                  wave_reg <= 1'b0;
                end
              end
              default: wave_reg <= wave_reg;
            endcase
          end else if (match) begin
            case (com)
              `TMR_COM_TOGGLE: wave_reg <= ~wave_reg;
              `TMR_COM_LOW: wave_reg <= 1'b0;
              `TMR_COM_HIGH: wave_reg <= 1'b1;
              default: wave_reg <= wave_reg;
            endcase
          end
        end
      end

      // pin driven only when direction is output
      // port keeps pin when action is zero
      // Registered for clean pins; adds one pclk of delay.
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_reg <= 1'b0;
          oe_n_reg <= 1'b1;
        end else begin
          pin_reg <= (com != `TMR_COM_OFF) ? wave_reg : port_d;
          oe_n_reg <= ~dir;
        end
      end

      assign mflag_w[k] = mflag_reg;
      assign wave_w[k] = wave_reg;
      assign act_w[16 * k +: 16] = act_reg;
      assign buf_w[16 * k +: 16] = buf_reg;
    end
  endgenerate

  // ----------------------------------------
  // Pins
  // ----------------------------------------
  assign pin_out_a = g_ch[0].pin_reg;
  assign pin_oe_n_a = g_ch[0].oe_n_reg;
  assign pin_out_b = g_ch[1].pin_reg;
  assign pin_oe_n_b = g_ch[1].oe_n_reg;

endmodule

/* test/tmr_pin_load.sv */
// Far-side load on one waveform pin, with a weak pull-down.
// Assumes the timer's pin value and its active-low output enable.
`timescale 1ns/1ps
module tmr_pin_load (
  input wire pin_out,
  input wire pin_oe_n,
  output wire pin_level
);
  // Released pin sinks to the pull-down, never holds the old value
  assign pin_level = pin_oe_n ? 1'h0 : pin_out;
endmodule

/* test/tmr_pwm_properties.sv */
// Checker for the timer's bus answers and pin behaviour.
// Assumes it is bound into tmr_pwm and sees only its ports.
`timescale 1ns/1ps
`include "tmr_consts.vh"
module tmr_pwm_properties (
  input wire pclk,
  input wire presetn,
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire port_data_a,
  input wire port_data_b,
  input wire pin_out_a,
  input wire pin_oe_n_a,
  input wire pin_out_b,
  input wire pin_oe_n_b
);
  wire wr_ctrl = psel && penable && pwrite && (paddr == `TMR_OFF_CTRL);
  wire unm = (paddr > `TMR_OFF_STATUS) || (paddr[1:0] != 2'h0);
  wire rd_setup = psel && !penable && !pwrite;
  reg [12:0] ctrl_reg;
  // ----
  // Shadow of the control word
  // ----
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= 13'h0000;
    end else if (wr_ctrl) begin
      ctrl_reg <= pwdata[12:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_err_phase; pslverr |-> psel && penable; endproperty
  a_err_phase: assert property (p_err_phase) else $error("pslverr outside access");
  property p_err_map; psel && penable |-> pslverr == unm; endproperty
  a_err_map: assert property (p_err_map) else $error("pslverr wrong for address");
  property p_rd_hold; !rd_setup |=> $stable(prdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("prdata moved without read");
  property p_rd_unm; rd_setup && unm |=> prdata == 32'h0; endproperty
  a_rd_unm: assert property (p_rd_unm) else $error("unmapped read not zero");
  property p_oe_a; $past(ctrl_reg[11]) == ctrl_reg[11] |-> pin_oe_n_a == !ctrl_reg[11];
  endproperty
  a_oe_a: assert property (p_oe_a) else $error("pin A enable wrong");
  property p_oe_b; $past(ctrl_reg[12]) == ctrl_reg[12] |-> pin_oe_n_b == !ctrl_reg[12];
  endproperty
  a_oe_b: assert property (p_oe_b) else $error("pin B enable wrong");
  property p_port; ctrl_reg[5:4] == 2'h0 && $past(ctrl_reg[5:4]) == 2'h0 && $past(presetn)
    |-> pin_out_a == $past(port_data_a); endproperty
  a_port: assert property (p_port) else $error("port value not on pin A");
  property p_hold; ctrl_reg[10:8] == 3'h0 && ctrl_reg[5:4] != 2'h0 && $past(ctrl_reg)
    == ctrl_reg && $past(ctrl_reg, 2) == ctrl_reg |-> $stable(pin_out_a); endproperty
  a_hold: assert property (p_hold) else $error("pin A moved while stopped");
  c_tog: cover property (ctrl_reg[5:4] == 2'h1 && $changed(pin_out_a));
  c_port: cover property (ctrl_reg[5:4] == 2'h0 && $changed(pin_out_a));
  c_err: cover property (pslverr);
  c_pin_b: cover property (!pin_oe_n_b && $changed(pin_out_b));
endmodule
bind tmr_pwm tmr_pwm_properties u_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .port_data_a(port_data_a),
  .port_data_b(port_data_b), .pin_out_a(pin_out_a), .pin_oe_n_a(pin_oe_n_a),
  .pin_out_b(pin_out_b), .pin_oe_n_b(pin_oe_n_b));

/* test/tb_top.sv */
// Self-checking bench for the timer: bus, clear-on-match and fast PWM.
// Assumes tmr_pwm, its constants header and one pin load per channel.
`timescale 1ns/1ps
`include "tmr_consts.vh"
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pd_a, pd_b, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, q;
  wire [31:0] prdata;
  wire pready, pslverr, po_a, oe_a, po_b, oe_b, lv_a, lv_b;
  int n_fail, cmp_count, n, i;
  int nt[5] = '{1, 8, 64, 256, 1024};
  logic [3:0] md[4] = '{4'h5, 4'h6, 4'h7, 4'he};
  logic [31:0] tp[4] = '{32'hff, 32'h1ff, 32'h3ff, 32'h400};
  tmr_pwm dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_data_a(pd_a), .port_data_b(pd_b),
    .pin_out_a(po_a), .pin_oe_n_a(oe_a), .pin_out_b(po_b), .pin_oe_n_b(oe_b));
  tmr_pin_load ld_a (.pin_out(po_a), .pin_oe_n(oe_a), .pin_level(lv_a));
  tmr_pin_load ld_b (.pin_out(po_b), .pin_oe_n(oe_b), .pin_level(lv_b));
  // ----
  // Shared tasks
  // ----
  task summarize;
    $display("fails %0d compares %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", s, x, g);
    end
  endtask
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // Length of the next whole level v on pin A; the watchdog bounds it
  task span(input logic v);
    while (lv_a !== ~v) @(posedge pclk);
    while (lv_a !== v) @(posedge pclk);
    n = 0;
    while (lv_a === v) begin
      @(posedge pclk);
      n++;
    end
  endtask
  function logic [31:0] cw(input [3:0] m, input [1:0] a, input [2:0] p, input d);
    cw = {19'h0, 1'h0, d, p, 2'h0, a, m};
  endfunction
  // ----
  // Scenarios
  // ----
  task t_regs;
    bus(1'h0, `TMR_OFF_CTRL, 32'h0);
    chk("ctrl", q, 32'h0);
    chk("oe_a", {31'h0, oe_a}, 32'h1);
    bus(1'h0, 12'h01c, 32'h0);
    chk("unm_rd", {q[30:0], e}, 32'h1);
    bus(1'h1, 12'h01c, 32'hffff);
    chk("unm_wr", {31'h0, e}, 32'h1);
  endtask
  task t_ctc;
    for (i = 0; i < 5; i++) begin
      bus(1'h1, `TMR_OFF_CMPA, 32'h1);
      bus(1'h1, `TMR_OFF_CTRL, cw(4'h4, 2'h1, 3'(i + 1), 1'h1));
      span(1'h1);
      chk("ctc_half", n, 2 * nt[i]);
    end
    bus(1'h1, `TMR_OFF_CTRL, cw(4'h4, 2'h1, 3'h0, 1'h1));
    bus(1'h0, `TMR_OFF_COUNT, 32'h0);
    chk("ctc_cnt", {31'h0, q < 32'h2}, 32'h1);
    bus(1'h0, `TMR_OFF_FLAGS, 32'h0);
    chk("ctc_mf", q & 32'h2, 32'h2);
    bus(1'h1, `TMR_OFF_FLAGS, 32'h2);
    bus(1'h0, `TMR_OFF_FLAGS, 32'h0);
    chk("mf_clr", q & 32'h2, 32'h0);
  endtask
  task t_wrap;
    bus(1'h1, `TMR_OFF_CAPTOP, 32'h100);
    bus(1'h1, `TMR_OFF_CTRL, cw(4'hc, 2'h0, 3'h1, 1'h0));
    repeat (200) @(posedge pclk);
    bus(1'h1, `TMR_OFF_CAPTOP, 32'h10);
    bus(1'h1, `TMR_OFF_FLAGS, 32'h9);
    bus(1'h0, `TMR_OFF_FLAGS, 32'h0);
    chk("no_match", q & 32'h9, 32'h0);
    repeat (65600) @(posedge pclk);
    bus(1'h0, `TMR_OFF_FLAGS, 32'h0);
    chk("wrapped", q & 32'h9, 32'h9);
  endtask
  // limits stay at least three; compare A is itself the limit
  task t_fp15;
    bus(1'h1, `TMR_OFF_CMPA, 32'h10);
    bus(1'h1, `TMR_OFF_CTRL, cw(4'hf, 2'h1, 3'h1, 1'h1));
    span(1'h1);
    chk("f15_half", n, 32'h11);
    bus(1'h1, `TMR_OFF_CMPA, 32'h7);
    bus(1'h0, `TMR_OFF_CMPA, 32'h0);
    chk("f15_buf", q, 32'h7);
    span(1'h1);
    span(1'h1);
    chk("f15_new", n, 32'h8);
  endtask
  task t_fpwm;
    bus(1'h1, `TMR_OFF_CTRL, cw(4'h5, 2'h3, 3'h1, 1'h1));
    bus(1'h1, `TMR_OFF_CMPA, 32'hff40);
    bus(1'h0, `TMR_OFF_CMPA, 32'h0);
    chk("mask", q, 32'h40);
    span(1'h0);
    span(1'h1);
    chk("fp_hi", n, 32'h41);
    span(1'h0);
    chk("fp_lo", n, 32'hbf);
    bus(1'h1, `TMR_OFF_CTRL, cw(4'h5, 2'h2, 3'h1, 1'h1));
    span(1'h0);
    span(1'h1);
    chk("inv_hi", n, 32'hbf);
    bus(1'h1, `TMR_OFF_CTRL, cw(4'h5, 2'h3, 3'h1, 1'h1));
    bus(1'h1, `TMR_OFF_CMPA, 32'hff);
    repeat (600) @(posedge pclk);
    n = 0;
    repeat (300) begin
      @(posedge pclk);
      if (lv_a !== 1'h1) n++;
    end
    chk("const", n, 32'h0);
    bus(1'h1, `TMR_OFF_CAPTOP, 32'h400);
    bus(1'h1, `TMR_OFF_CMPA, 32'h0);
    for (i = 0; i < 4; i++) begin
      bus(1'h1, `TMR_OFF_CTRL, cw(md[i], 2'h3, 3'h1, 1'h1));
      span(1'h0);
      span(1'h0);
      chk("fp_top", n, tp[i]);
    end
    span(1'h1);
    chk("spike", n, 32'h1);
    bus(1'h1, `TMR_OFF_FLAGS, 32'h9);
    repeat (1100) @(posedge pclk);
    bus(1'h0, `TMR_OFF_FLAGS, 32'h0);
    chk("fp_flags", q & 32'h9, 32'h9);
  endtask
  task t_port;
    bus(1'h1, `TMR_OFF_CTRL, cw(4'h4, 2'h0, 3'h1, 1'h1));
    pd_a <= 1'h1;
    repeat (3) @(posedge pclk);
    chk("port_hi", {31'h0, lv_a}, 32'h1);
    bus(1'h1, `TMR_OFF_CTRL, cw(4'h4, 2'h0, 3'h1, 1'h0));
    repeat (3) @(posedge pclk);
    chk("pin_in", {31'h0, lv_a}, 32'h0);
  endtask
  // Channel B: port pass-through, masked buffered compare, flag and status
  task t_chb;
    pd_b <= 1'h1;
    bus(1'h1, `TMR_OFF_CTRL, 32'h1000);
    repeat (3) @(posedge pclk);
    chk("port_b", {30'h0, oe_b, lv_b}, 32'h1);
    bus(1'h1, `TMR_OFF_CTRL, 32'h11c5);
    bus(1'h1, `TMR_OFF_CMPB, 32'hf080);
    bus(1'h0, `TMR_OFF_CMPB, 32'h0);
    chk("mask_b", q, 32'h80);
    repeat (600) @(posedge pclk);
    n = 0;
    // Two whole periods, so the phase of the window does not matter
    repeat (512) begin
      @(posedge pclk);
      if (lv_b === 1'h1) n++;
    end
    chk("fp_b_hi", n, 32'h102);
    bus(1'h1, `TMR_OFF_FLAGS, 32'h4);
    repeat (300) @(posedge pclk);
    bus(1'h0, `TMR_OFF_FLAGS, 32'h0);
    chk("mf_b", q & 32'h4, 32'h4);
    bus(1'h1, `TMR_OFF_CMPB, 32'hff);
    repeat (300) @(posedge pclk);
    bus(1'h0, `TMR_OFF_STATUS, 32'h0);
    chk("wave_b", q & 32'h2, 32'h2);
  endtask
  // ----
  // Clock, sequence and watchdog
  // ----
  initial begin
    pclk = 1'h0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pd_a = 1'h0;
    pd_b = 1'h0;
    n_fail = 0;
    cmp_count = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    t_regs;
    t_ctc;
    t_wrap;
    t_fp15;
    t_fpwm;
    t_port;
    t_chb;
    summarize;
  end
  // Longest path is the 16-bit wrap, about 66k cycles
  initial begin
    #2000000;
    n_fail++;
    summarize;
  end
endmodule
